// [design/tpwm_pkg.sv]
// Functional notes
// R1: one-pulse runs only while its enable is set
// R2: edge select picks capture one trigger edge
// R3: trigger loads counter, pulse level, flag, capture
// R4: trigger flag raises irq when capture irq enabled
// R5: flag clears after status read, low byte access
// R6: compare one match ends pulse, after level
// R7: one-pulse: no compare flag one, no pin two
// R8: pwm enable overrides one-pulse enable
// R9: equal levels give a constant output
// R10: one-pulse: capture two still works, not one
// R11: pwm matches drive level one and two
// R12: pwm compare two match reloads counter
// R13: high pulse equals compare two minus one
// R14: length is compare value plus five ticks
// R15: high byte write inhibits compare until low
// R16: pwm never sets compare flags
// R17: pwm compare two sets capture flag one
// R18: pwm: capture one off, capture two works
// R19: wait mode leaves timer running, irq wakes
// R20: halt freezes counter, resumes from frozen count
// R21: capture edge in halt lands at exit
// R22: clock select gives div4, div2, div8, external
// R23: pin one carries both levels when enabled
// R24: counter increments per tick and wraps
package tpwm_pkg;

    // -------------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_CAP1_HI  = 8'h0c;
    localparam logic [7:0] OFF_CAP1_LO  = 8'h10;
    localparam logic [7:0] OFF_CAP2_HI  = 8'h14;
    localparam logic [7:0] OFF_CAP2_LO  = 8'h18;
    localparam logic [7:0] OFF_CMP1_HI  = 8'h1c;
    localparam logic [7:0] OFF_CMP1_LO  = 8'h20;
    localparam logic [7:0] OFF_CMP2_HI  = 8'h24;
    localparam logic [7:0] OFF_CMP2_LO  = 8'h28;
    localparam logic [7:0] OFF_CNT_HI   = 8'h2c;
    localparam logic [7:0] OFF_CNT_LO   = 8'h30;

    // -------------------------------------------------------------------
    // control field positions
    // -------------------------------------------------------------------
    localparam int BIT_CAP_IRQ_EN   = 7;
    localparam int BIT_CMP_IRQ_EN   = 6;
    localparam int BIT_OVF_IRQ_EN   = 5;
    localparam int BIT_PULSE_LVL    = 2;
    localparam int BIT_EDGE_ONE     = 1;
    localparam int BIT_AFTER_LVL    = 0;
    localparam int BIT_PIN_ONE_EN   = 7;
    localparam int BIT_PIN_TWO_EN   = 6;
    localparam int BIT_ONE_PULSE_EN = 5;
    localparam int BIT_PWM_EN       = 4;
    localparam int BIT_CLK_SEL_LO   = 2;
    localparam int BIT_EDGE_TWO     = 1;
    localparam int BIT_EXT_EDGE     = 0;

    // status flag indices, status byte is {flags, 3'b000}
    localparam int FLG_CAP1 = 4;
    localparam int FLG_CMP1 = 3;
    localparam int FLG_OVF  = 2;
    localparam int FLG_CAP2 = 1;
    localparam int FLG_CMP2 = 0;

    // -------------------------------------------------------------------
    // values after reset and mode constants
    // -------------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] CNT_RESET     = 16'hfffc;
    localparam logic [15:0] CNT_RELOAD    = 16'hfffc;
    localparam logic [15:0] CNT_TOP       = 16'hffff;
    localparam logic [15:0] CAP_OPM_VALUE = 16'hfffd;
    localparam logic [15:0] CMP_RESET     = 16'h8000;
    localparam logic [15:0] CAP_RESET     = 16'h0000;

    // clock select codes and last divider count of each divider
    localparam logic [1:0] SEL_DIV4 = 2'h0;
    localparam logic [1:0] SEL_DIV2 = 2'h1;
    localparam logic [1:0] SEL_DIV8 = 2'h2;
    localparam logic [1:0] SEL_EXT  = 2'h3;
    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    typedef enum logic [2:0] {
        MODE_FREE      = 3'b001,
        MODE_ONE_PULSE = 3'b010,
        MODE_PWM       = 3'b100
    } tpwm_mode_type;

endpackage

// [design/tpwm_prescaler.sv]
`timescale 1ns/1ns
module tpwm_prescaler
    import tpwm_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // selection
    input  wire logic [1:0] clock_select,
    input  wire logic       ext_edge_rise,
    input  wire logic       ext_clock_in,
    input  wire logic       run,
    // timer tick
    output logic            tick
);

    logic [2:0] div_reg;
    logic       ext_prev_reg;
    logic       tick_reg;

    // -------------------------------------------------------------------
    // divider decode
    // -------------------------------------------------------------------
    wire [2:0] div_last = (clock_select == SEL_DIV2) ? DIV2_LAST :
                          (clock_select == SEL_DIV8) ? DIV8_LAST : DIV4_LAST; // R22
    wire       ext_sel  = (clock_select == SEL_EXT);
    wire       ext_hit  = ext_edge_rise ? (ext_clock_in & ~ext_prev_reg)
                                        : (~ext_clock_in & ext_prev_reg);
    wire       div_hit  = (div_reg >= div_last);
    wire       tick_next = run & (ext_sel ? ext_hit : div_hit); // R14

    // divider holds in halt so the phase resumes where it stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg      <= 3'h0;
            ext_prev_reg <= 1'b0;
            tick_reg     <= 1'b0;
        end else begin
            div_reg      <= (!run) ? div_reg : (div_hit ? 3'h0 : 3'(div_reg + 3'h1));
            ext_prev_reg <= ext_clock_in;
            tick_reg     <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule

// [design/tpwm_timer.sv]
`timescale 1ns/1ns
module tpwm_timer
    import tpwm_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // capture pins and external timer clock
    input  wire logic        capture_input_one,
    input  wire logic        capture_input_two,
    input  wire logic        ext_clock_in,
    // compare pins
    output logic             compare_output_one,
    output logic             compare_output_one_oe,
    output logic             compare_output_two,
    output logic             compare_output_two_oe,
    // system
    input  wire logic        halt_mode,
    input  wire logic        irq_mask,
    output logic             timer_irq
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [7:0]  ctrl_one_reg;
    logic [7:0]  ctrl_two_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] cmp_one_reg;
    logic [15:0] cmp_two_reg;
    logic [15:0] cap_one_reg;
    logic [15:0] cap_two_reg;
    logic [4:0]  flag_reg;
    logic [4:0]  arm_reg;
    logic [1:0]  inh_reg;
    logic [1:0]  pend_reg;
    logic        cap1_prev_reg;
    logic        cap2_prev_reg;
    logic        halt_prev_reg;
    logic        oc1_reg;
    logic        oc1_next;
    logic        oc2_reg;
    logic        oc1_oe_reg;
    logic        oc2_oe_reg;
    logic        irq_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        tick;
    tpwm_mode_type mode;

    // -------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------
    wire acc_first = psel & penable & ~pready_reg;
    wire acc_done  = psel & penable & pready_reg;
    wire wr        = acc_done & pwrite;
    wire hit_c1    = (paddr == OFF_CTRL_ONE);
    wire hit_c2    = (paddr == OFF_CTRL_TWO);
    wire hit_st    = (paddr == OFF_STATUS);
    wire hit_p1h   = (paddr == OFF_CAP1_HI);
    wire hit_p1l   = (paddr == OFF_CAP1_LO);
    wire hit_p2h   = (paddr == OFF_CAP2_HI);
    wire hit_p2l   = (paddr == OFF_CAP2_LO);
    wire hit_m1h   = (paddr == OFF_CMP1_HI);
    wire hit_m1l   = (paddr == OFF_CMP1_LO);
    wire hit_m2h   = (paddr == OFF_CMP2_HI);
    wire hit_m2l   = (paddr == OFF_CMP2_LO);
    wire hit_nh    = (paddr == OFF_CNT_HI);
    wire hit_nl    = (paddr == OFF_CNT_LO);
    wire mapped    = hit_c1 | hit_c2 | hit_st | hit_p1h | hit_p1l | hit_p2h | hit_p2l
                   | hit_m1h | hit_m1l | hit_m2h | hit_m2l | hit_nh | hit_nl;

    // read selection, all registers are one byte wide
    wire [7:0] rd_byte = hit_c1  ? ctrl_one_reg :
                         hit_c2  ? ctrl_two_reg :
                         hit_st  ? {flag_reg, 3'h0} :
                         hit_p1h ? cap_one_reg[15:8] :
                         hit_p1l ? cap_one_reg[7:0] :
                         hit_p2h ? cap_two_reg[15:8] :
                         hit_p2l ? cap_two_reg[7:0] :
                         hit_m1h ? cmp_one_reg[15:8] :
                         hit_m1l ? cmp_one_reg[7:0] :
                         hit_m2h ? cmp_two_reg[15:8] :
                         hit_m2l ? cmp_two_reg[7:0] :
                         hit_nh  ? cnt_reg[15:8] :
                         hit_nl  ? cnt_reg[7:0] : 8'h00;

    // second step of flag clearing: any access to the matching low byte
    wire [4:0] lo_acc = {acc_done & hit_p1l, acc_done & hit_m1l, acc_done & hit_nl,
                         acc_done & hit_p2l, acc_done & hit_m2l};
    wire       stat_rd = acc_first & ~pwrite & hit_st;

    // -------------------------------------------------------------------
    // mode and events
    // -------------------------------------------------------------------
    wire pwm_en = ctrl_two_reg[BIT_PWM_EN];
    wire opm_en = ctrl_two_reg[BIT_ONE_PULSE_EN];
    assign mode = pwm_en ? MODE_PWM : (opm_en ? MODE_ONE_PULSE : MODE_FREE); // R1 R8
    wire m_pwm  = (mode == MODE_PWM);
    wire m_one  = (mode == MODE_ONE_PULSE);
    wire m_free = (mode == MODE_FREE);

    // capture pins are synchronous, edge found against last sample
    wire rise1  = capture_input_one & ~cap1_prev_reg;
    wire fall1  = ~capture_input_one & cap1_prev_reg;
    wire rise2  = capture_input_two & ~cap2_prev_reg;
    wire fall2  = ~capture_input_two & cap2_prev_reg;
    wire edge1  = ctrl_one_reg[BIT_EDGE_ONE] ? rise1 : fall1; // R2
    // capture two keeps its own edge select in every mode
    wire edge2s = ctrl_two_reg[BIT_EDGE_TWO] ? rise2 : fall2;
    wire hexit  = halt_prev_reg & ~halt_mode;

    // halt gates ticks and triggers, so the count stays frozen
    wire run_tick = tick & ~halt_mode; // R20 R19
    wire opm_trig = m_one & edge1 & ~halt_mode; // R3
    wire m1 = run_tick & (cnt_reg == cmp_one_reg) & ~inh_reg[0]; // R15
    wire m2 = run_tick & (cnt_reg == cmp_two_reg) & ~inh_reg[1]; // R15
    wire reload = opm_trig | (m_pwm & m2); // R12 R14
    wire ovf = run_tick & (cnt_reg == CNT_TOP) & ~reload;

    // capture one is cut off in pulse modes, capture two always works
    wire cap1_evt = m_free & ((edge1 & ~halt_mode) | (hexit & pend_reg[0])); // R10 R18 R21
    wire cap2_evt = (edge2s & ~halt_mode) | (hexit & pend_reg[1]); // R10 R18 R21

    wire [4:0] flag_set = {opm_trig | (m_pwm & m2) | cap1_evt, // R3 R17
                           m_free & m1, // R7 R16
                           ovf,
                           cap2_evt,
                           ~m_pwm & m2}; // R7 R16
    wire [4:0] flag_clr = arm_reg & lo_acc; // R5

    wire irq_next = ~irq_mask & ((ctrl_one_reg[BIT_CAP_IRQ_EN] & (flag_reg[FLG_CAP1]
                  | flag_reg[FLG_CAP2])) | (ctrl_one_reg[BIT_CMP_IRQ_EN]
                  & (flag_reg[FLG_CMP1] | flag_reg[FLG_CMP2]))
                  | (ctrl_one_reg[BIT_OVF_IRQ_EN] & flag_reg[FLG_OVF])); // R4 R17 R19

    // counter next value, reload wins over increment
    always_comb begin
        cnt_next = cnt_reg;
        if (reload) begin
            cnt_next = CNT_RELOAD; // R3 R12
        end else if (run_tick) begin
            cnt_next = 16'(cnt_reg + 16'h0001); // R24
        end
    end

    // pin one level: trigger and period start load the pulse level
    always_comb begin
        oc1_next = oc1_reg;
        if (opm_trig || (m_pwm && m2)) begin
            oc1_next = ctrl_one_reg[BIT_PULSE_LVL]; // R3 R11 R23
        end else if (m1) begin
            oc1_next = ctrl_one_reg[BIT_AFTER_LVL]; // R6 R11 R13
        end
    end

    // -------------------------------------------------------------------
    // prescaler
    // -------------------------------------------------------------------
    tpwm_prescaler u_prescale_factor (
        .pclk          (pclk),
        .presetn       (presetn),
        .clock_select  (ctrl_two_reg[BIT_CLK_SEL_LO +: 2]),
        .ext_edge_rise (ctrl_two_reg[BIT_EXT_EDGE]),
        .ext_clock_in  (ext_clock_in),
        .run           (~halt_mode),
        .tick          (tick)
    );

    // -------------------------------------------------------------------
    // flags, set wins over clear
    // -------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_reg[gi] <= 1'b0;
                    arm_reg[gi]  <= 1'b0;
                end else begin
                    flag_reg[gi] <= flag_set[gi] | (flag_reg[gi] & ~flag_clr[gi]); // R5
                    arm_reg[gi]  <= ~flag_clr[gi] & (arm_reg[gi] | (stat_rd & flag_reg[gi]));
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // counter, captures, halt tracking
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg       <= CNT_RESET;
            cap_one_reg   <= CAP_RESET;
            cap_two_reg   <= CAP_RESET;
            pend_reg      <= 2'h0;
            cap1_prev_reg <= 1'b0;
            cap2_prev_reg <= 1'b0;
            halt_prev_reg <= 1'b0;
        end else begin
            cnt_reg       <= cnt_next;
            cap1_prev_reg <= capture_input_one;
            cap2_prev_reg <= capture_input_two;
            halt_prev_reg <= halt_mode;
            if (opm_trig) begin
                cap_one_reg <= CAP_OPM_VALUE; // R3
            end else if (cap1_evt) begin
                cap_one_reg <= cnt_reg;
            end
            if (cap2_evt) begin
                cap_two_reg <= cnt_reg; // R10 R18
            end
            // edges seen in halt are held until the exit
            pend_reg[0] <= halt_mode ? (pend_reg[0] | (m_free & edge1)) : 1'b0; // R21
            pend_reg[1] <= halt_mode ? (pend_reg[1] | edge2s) : 1'b0; // R21
        end
    end

    // -------------------------------------------------------------------
    // software registers
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one_reg <= CTRL_RESET;
            ctrl_two_reg <= CTRL_RESET;
            cmp_one_reg  <= CMP_RESET;
            cmp_two_reg  <= CMP_RESET;
            inh_reg      <= 2'h0;
        end else if (wr) begin
            if (hit_c1) ctrl_one_reg <= pwdata[7:0];
            if (hit_c2) ctrl_two_reg <= pwdata[7:0];
            if (hit_m1h) cmp_one_reg[15:8] <= pwdata[7:0];
            if (hit_m1l) cmp_one_reg[7:0] <= pwdata[7:0];
            if (hit_m2h) cmp_two_reg[15:8] <= pwdata[7:0];
            if (hit_m2l) cmp_two_reg[7:0] <= pwdata[7:0];
            // a torn 16-bit update must not match halfway
            if (hit_m1h) inh_reg[0] <= 1'b1; // R15
            if (hit_m1l) inh_reg[0] <= 1'b0; // R15
            if (hit_m2h) inh_reg[1] <= 1'b1; // R15
            if (hit_m2l) inh_reg[1] <= 1'b0; // R15
        end
    end

    // -------------------------------------------------------------------
    // pins, interrupt and bus answer, all from flops
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc1_reg     <= 1'b0;
            oc2_reg     <= 1'b0;
            oc1_oe_reg  <= 1'b0;
            oc2_oe_reg  <= 1'b0;
            irq_reg     <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            oc1_reg     <= oc1_next; // R9
            oc2_reg     <= (m_free & m2) ? ctrl_one_reg[BIT_PULSE_LVL] : oc2_reg; // R7
            oc1_oe_reg  <= ctrl_two_reg[BIT_PIN_ONE_EN]; // R23
            oc2_oe_reg  <= ctrl_two_reg[BIT_PIN_TWO_EN] & m_free; // R7
            irq_reg     <= irq_next;
            pready_reg  <= acc_first;
            pslverr_reg <= acc_first & ~mapped;
            if (acc_first && !pwrite) prdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    assign compare_output_one    = oc1_reg;
    assign compare_output_one_oe = oc1_oe_reg;
    assign compare_output_two    = oc2_reg;
    assign compare_output_two_oe = oc2_oe_reg;
    assign timer_irq             = irq_reg;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    opm_load_a: assert property (opm_trig |=> (cnt_reg == CNT_RELOAD) // R3
        && (cap_one_reg == CAP_OPM_VALUE) && flag_reg[FLG_CAP1]
        && oc1_reg == $past(ctrl_one_reg[BIT_PULSE_LVL]))
        else $error("one-pulse trigger did not load counter and capture");
    opm_end_a: assert property (m_one && m1 && !opm_trig |=> // R6
        oc1_reg == $past(ctrl_one_reg[BIT_AFTER_LVL]))
        else $error("one-pulse match did not drive after level");
    opm_nocmp_a: assert property (!m_free && !flag_reg[FLG_CMP1] |=> !flag_reg[FLG_CMP1]) // R7
        else $error("compare flag one set in pulse mode");
    pwm_nocmp_a: assert property (m_pwm && !flag_reg[FLG_CMP2] |=> !flag_reg[FLG_CMP2]) // R16
        else $error("compare flag two set in pwm mode");
    pwm_over_a: assert property (pwm_en && opm_en && edge1 && !tick |=> $stable(cnt_reg)) // R8
        else $error("capture one edge acted in pwm mode");
    pwm_period_a: assert property (m_pwm && m2 |=> (cnt_reg == CNT_RELOAD) // R12
        && flag_reg[FLG_CAP1] && oc1_reg == $past(ctrl_one_reg[BIT_PULSE_LVL]))
        else $error("pwm period end not handled");
    pwm_level_a: assert property (m_pwm && m1 && !m2 |=> // R11
        oc1_reg == $past(ctrl_one_reg[BIT_AFTER_LVL]))
        else $error("pwm compare one level wrong");
    flag_keep_a: assert property (flag_reg[FLG_CAP1] && !arm_reg[FLG_CAP1] |=> // R5
        flag_reg[FLG_CAP1])
        else $error("capture flag one cleared without status read");
    halt_freeze_a: assert property (halt_mode |=> $stable(cnt_reg)) // R20
        else $error("counter moved during halt");
    cap_irq_a: assert property (flag_reg[FLG_CAP1] && ctrl_one_reg[BIT_CAP_IRQ_EN] // R4
        && !irq_mask |=> timer_irq)
        else $error("capture flag did not raise interrupt");
    inh_a: assert property (inh_reg[0] |-> !m1) // R15
        else $error("compare one matched while inhibited");

    opm_trig_c: cover property (opm_trig ##[1:1000] (m_one && m1));
    pwm_cycle_c: cover property (m_pwm && m1 ##[1:1000] (m_pwm && m2));
    halt_wake_c: cover property (halt_mode && pend_reg[1] ##1 hexit);
    flag_clr_c: cover property (flag_clr[FLG_CAP1]);

endmodule

// [sim/test_timer_one_pulse_pwm_modes.sv]
`timescale 1ns/1ns
module test_timer_one_pulse_pwm_modes;
    import tpwm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, cap1, cap2, extc, out1, out1_oe, out2, out2_oe;
    logic halt_mode = 1'b0, irq_mask = 1'b0, timer_irq;
    int failures = 0, n_tests = 0, n;

    tpwm_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_input_one(cap1), .capture_input_two(cap2),
        .ext_clock_in(extc), .compare_output_one(out1), .compare_output_one_oe(out1_oe),
        .compare_output_two(out2), .compare_output_two_oe(out2_oe),
        .halt_mode(halt_mode), .irq_mask(irq_mask), .timer_irq(timer_irq));
    tpwm_partner i_partner (.pclk(pclk), .capture_input_one(cap1), .capture_input_two(cap2),
        .ext_clock_in(extc), .compare_output_one(out1), .compare_output_one_oe(out1_oe));

    // 10 MHz clock
    initial begin
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // apb transfer; waits on pready, a hang is left to the watchdog
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic test_regs();
        apb(0, OFF_CTRL_ONE, 0); chk("ctrl_one", rd, 32'h0);
        apb(0, OFF_CMP1_HI, 0); chk("cmp1_hi", rd, 32'h80);
        apb(0, 8'h3c, 0); chk("unmapped err", {31'h0, err}, 32'h1);
        $display("test regs done");
    endtask

    task automatic test_one_pulse();
        apb(1, OFF_CMP1_HI, 0); apb(1, OFF_CMP1_LO, 32'h10);
        apb(1, OFF_CTRL_ONE, 32'h86); apb(1, OFF_CTRL_TWO, 32'he4);
        i_partner.trigger_one();
        n = 0; while (out1 !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
        chk("pulse start", {31'h0, out1}, 32'h1);
        chk("pins oe1 oe2 out2", {29'h0, out1_oe, out2_oe, out2}, 32'h4);
        n = 0; while (out1 !== 1'b0 && n < 400) begin @(posedge pclk); n++; end
        chk("pulse end", {31'h0, out1}, 32'h0);
        chk("irq", {31'h0, timer_irq}, 32'h1);
        apb(0, OFF_CAP1_HI, 0); chk("cap1 hi", rd, 32'hff);
        apb(0, OFF_CAP1_LO, 0); chk("cap1 lo", rd, 32'hfd);
        apb(0, OFF_STATUS, 0); chk("flags", rd & 32'h48, 32'h0);
        chk("cap flag", rd & 32'h80, 32'h80);
        apb(0, OFF_CAP1_LO, 0); apb(0, OFF_STATUS, 0);
        chk("cap flag clear", rd & 32'h80, 32'h0);
        $display("test one pulse done");
    endtask

    task automatic test_pwm();
        apb(1, OFF_CMP2_HI, 0); apb(1, OFF_CMP2_LO, 32'h10);
        apb(1, OFF_CMP1_HI, 0); apb(1, OFF_CMP1_LO, 32'h08);
        apb(1, OFF_CTRL_ONE, 32'h01);
        // restart the count by a trigger, else the first period waits for a wrap
        i_partner.trigger_one();
        apb(1, OFF_CTRL_TWO, 32'hb4);
        // clear the trigger's capture flag so only pwm can set it again
        apb(0, OFF_STATUS, 0); apb(0, OFF_CAP1_LO, 0);
        i_partner.trigger_one();
        repeat (200) @(posedge pclk);
        chk("period", {16'h0, i_partner.last_period}, (32'h10 + 5) * 2);
        chk("high", {16'h0, i_partner.last_high}, (32'h10 - 32'h08) * 2);
        apb(0, OFF_STATUS, 0);
        chk("pwm flags", rd & 32'hc8, 32'h80);
        apb(0, OFF_CAP1_LO, 0); chk("cap1 kept", rd, 32'hfd);
        $display("test pwm done");
    endtask

    task automatic test_halt();
        logic [31:0] first;
        halt_mode <= 1'b1;
        apb(0, OFF_CNT_LO, 0); first = rd;
        repeat (20) @(posedge pclk);
        apb(0, OFF_CNT_LO, 0); chk("frozen count", rd, first);
        halt_mode <= 1'b0;
        repeat (20) @(posedge pclk);
        apb(0, OFF_CNT_LO, 0); chk("count resumes", {31'h0, rd != first}, 32'h1);
        $display("test halt done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_one_pulse();
        test_pwm();
        test_halt();
        test_done();
    end

    // watchdog, well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        test_done();
    end
endmodule

// [sim/tpwm_partner.sv]
`timescale 1ns/1ns
module tpwm_partner (
    // clock
    input  wire logic pclk,
    // pins into the timer
    output logic      capture_input_one,
    output logic      capture_input_two,
    output logic      ext_clock_in,
    // pin from the timer
    input  wire logic compare_output_one,
    input  wire logic compare_output_one_oe
);
    logic        load_level;
    logic        prev_level;
    logic [15:0] per_cnt;
    logic [15:0] high_cnt;
    logic [15:0] last_period;
    logic [15:0] last_high;

    // sources stay driven at all times, the pins are plain floating inputs
    initial begin
        capture_input_one = 1'b0;
        capture_input_two = 1'b0;
        ext_clock_in      = 1'b0;
        prev_level        = 1'b0;
        per_cnt           = 16'h0000;
        high_cnt          = 16'h0000;
        last_period       = 16'h0000;
        last_high         = 16'h0000;
    end

    // load has a pull-down, so a released pin reads low
    assign load_level = compare_output_one_oe ? compare_output_one : 1'b0;

    // one four-clock high pulse on capture pin one, rising then falling, launched after a clock edge
    task automatic trigger_one();
        @(posedge pclk);
        capture_input_one <= 1'b1;
        repeat (4) @(posedge pclk);
        capture_input_one <= 1'b0;
    endtask

    // measure period between rises and width of each high phase
    always @(posedge pclk) begin
        prev_level <= load_level;
        if (load_level && !prev_level) begin
            last_period <= per_cnt;
            per_cnt     <= 16'h0001;
            high_cnt    <= 16'h0001;
        end else begin
            per_cnt <= per_cnt + 16'h0001;
            if (load_level) begin
                high_cnt <= high_cnt + 16'h0001;
            end
        end
        if (!load_level && prev_level) begin
            last_high <= high_cnt;
        end
    end
endmodule
